//--- verilog/nvw_params.svh
`ifndef NVW_PARAMS_SVH
`define NVW_PARAMS_SVH

// Register and store map
`define NVW_CTRL_ADDR 16'hFFD8
`define NVW_CTRL_RST 8'h08
`define NVW_STORE_BASE 16'hFD00
`define NVW_STORE_DEPTH 32
`define NVW_STORE_AW 5

// Control register fields
`define NVW_FIX0_BIT 7
`define NVW_CS_MSB 6
`define NVW_CS_LSB 4
`define NVW_FIX1_BIT 3
`define NVW_RE_BIT 2
`define NVW_WST_BIT 1
`define NVW_WE_BIT 0

// Count clock select codes and write length in count clock periods
`define NVW_CS_TIMER 3'h6
`define NVW_CS_PROHIB 3'h7
`define NVW_WRITE_TICKS 8'h91

`endif

//--- verilog/nvw_pkg.sv
package nvw_pkg;
	typedef logic [7:0] nvw_byte_type;
	typedef logic [2:0] nvw_clk_sel_type;
	typedef enum logic [1:0] {
		NVW_IDLE = 2'h0,
		NVW_BUSY = 2'h1,
		NVW_DONE = 2'h3
	} nvw_state_type;
endpackage

//--- verilog/nvw_timer_if.sv
`timescale 1ns/100ps
interface nvw_timer_if;
	logic [2:0] clk_sel;
	logic timer_src;
	logic start;
	logic busy;
	logic done;
	modport ctrl (output clk_sel, output timer_src, output start, input busy, input done);
	modport timer (input clk_sel, input timer_src, input start, output busy, output done);
endinterface

//--- verilog/nvw_write_timer.sv
`timescale 1ns/100ps
`include "nvw_params.svh"
module nvw_write_timer (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	nvw_timer_if.timer tmr
);
	import nvw_pkg::*;

	// ==========================================
	// Count clock generation
	logic [7:0] pre_r;
	logic src_prev_r;
	logic [7:0] mask;
	logic tick;
	logic [7:0] cnt_r;
	logic done_r;

	always_comb begin
		mask = 8'h07;
		case (tmr.clk_sel)
			3'h0: mask = 8'h07;
			3'h1: mask = 8'h0F;
			3'h2: mask = 8'h1F;
			3'h3: mask = 8'h3F;
			3'h4: mask = 8'h7F;
			3'h5: mask = 8'hFF;
			default: mask = 8'h00;
		endcase
	end

	always_comb begin
		if (tmr.clk_sel == `NVW_CS_TIMER) begin // [RULE_08]
			tick = tmr.timer_src & ~src_prev_r;
		end else if (tmr.clk_sel == `NVW_CS_PROHIB) begin
			tick = 1'b0;
		end else begin
			tick = ((pre_r & mask) == mask); // [RULE_07]
		end
	end

	// Prescaler restarts with each write so the length is exact
	always_ff @(posedge sys_clk_i) begin
		if (srst_i || tmr.start) begin
			pre_r <= 8'h00;
		end else begin
			pre_r <= pre_r + 8'h01;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			src_prev_r <= 1'b0;
		end else begin
			src_prev_r <= tmr.timer_src;
		end
	end

	// ==========================================
	// Write length counter
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			cnt_r <= 8'h00;
		end else if (tmr.start) begin
			cnt_r <= `NVW_WRITE_TICKS; // [RULE_13]
		end else if (tick && cnt_r != 8'h00) begin
			cnt_r <= cnt_r - 8'h01;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			done_r <= 1'b0;
		end else begin
			done_r <= tick && (cnt_r == 8'h01); // [RULE_03]
		end
	end

	assign tmr.busy = (cnt_r != 8'h00);
	assign tmr.done = done_r;

	// ==========================================
	// Checks
	logic [7:0] seen_r;
	always_ff @(posedge sys_clk_i) begin
		if (srst_i || tmr.start) begin
			seen_r <= 8'h00;
		end else if (tick && tmr.busy) begin
			seen_r <= seen_r + 8'h01;
		end
	end

	tick_count_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE_13]
		$rose(done_r) |-> seen_r == 8'h91)
		else $error("write did not last 145 count clock periods");

	timer_select_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE_08]
		(tmr.clk_sel == 3'h6) && tmr.timer_src && !src_prev_r |-> tick)
		else $error("timer output edge not used as count clock");

	div_tick_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE_07]
		(tmr.clk_sel < 3'h6) && tick |->
		(({1'b0, pre_r} & ((9'h008 << tmr.clk_sel) - 9'h001)) ==
		((9'h008 << tmr.clk_sel) - 9'h001)))
		else $error("divided count clock tick off its boundary");
endmodule

//--- verilog/nvw_write_control.sv
`timescale 1ns/100ps
`include "nvw_params.svh"
// Function
// RULE_01 - Store holds 32 bytes that are kept, not cleared by reset.
// RULE_02 - Store is read and written with plain byte accesses.
// RULE_03 - End of each store write raises a write-done interrupt pulse.
// RULE_04 - Reset loads the control register at FFD8H with 08H.
// RULE_05 - Control register takes both single-bit and whole-byte writes.
// RULE_06 - Layout: 0, clock select 6:4, 1, read enable, status, write enable.
// RULE_07 - Select codes 0-5 divide clock by 8..256, 6 timer, 7 prohibited.
// RULE_08 - Code 110 uses the timer output as write count clock.
// RULE_09 - Enables: none standby, read only, both read-write; write-only prohibited.
// RULE_10 - Status 0 means idle; writes still need write enable.
// RULE_11 - Status 1 while writing; store locked, status read-only.
// RULE_12 - Store writes during status 1 are ignored.
// RULE_13 - Each write lasts 145 periods of the selected count clock.
// RULE_14 - Clearing read enable also clears write enable.
// RULE_15 - Bits 7 and 3 ignore writes and read 0 and 1.
module nvw_write_control (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic [15:0] mem_addr_i,
	input wire logic mem_rd_i,
	input wire logic mem_wr_i,
	input wire logic mem_bit_i,
	input wire logic [2:0] mem_bit_sel_i,
	input wire nvw_pkg::nvw_byte_type mem_wdata_i,
	input wire logic timer_out_i,
	output nvw_pkg::nvw_byte_type mem_rdata_o,
	output logic mem_rvalid_o,
	output logic nv_write_done_irq_o
);
	import nvw_pkg::*;

	nvw_timer_if tif();

	nvw_write_timer u_timer (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.tmr(tif.timer)
	);

	// ==========================================
	// Decode
	nvw_byte_type ctrl_r;
	nvw_byte_type ctrl_wval;
	nvw_byte_type store_mem [0:`NVW_STORE_DEPTH-1];
	nvw_state_type state_r;
	nvw_state_type state_nxt;
	logic [`NVW_STORE_AW-1:0] wr_addr_r;
	nvw_byte_type wr_data_r;
	nvw_byte_type rdata_r;
	logic rvalid_r;
	logic irq_r;
	logic ctrl_hit;
	logic store_hit;
	logic [`NVW_STORE_AW-1:0] store_idx;
	logic busy;
	logic busy_nxt;
	logic store_wr_ok;

	assign ctrl_hit = (mem_addr_i == `NVW_CTRL_ADDR);
	assign store_hit = (mem_addr_i[15:5] == `NVW_STORE_BASE >> 5);
	assign store_idx = mem_addr_i[`NVW_STORE_AW-1:0];
	assign busy = (state_r != NVW_IDLE);
	// [RULE_10] [RULE_12]
	assign store_wr_ok = mem_wr_i && store_hit && !busy && ctrl_r[`NVW_RE_BIT] &&
		ctrl_r[`NVW_WE_BIT];

	// Merge a single-bit write into the current value
	always_comb begin
		ctrl_wval = mem_wdata_i;
		if (mem_bit_i) begin // [RULE_05]
			ctrl_wval = ctrl_r;
			ctrl_wval[mem_bit_sel_i] = mem_wdata_i[0];
		end
	end

	// ==========================================
	// Write sequencer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			NVW_IDLE: begin
				if (store_wr_ok) begin
					state_nxt = NVW_BUSY;
				end
			end
			NVW_BUSY: begin
				if (tif.done) begin
					state_nxt = NVW_DONE;
				end
			end
			NVW_DONE: state_nxt = NVW_IDLE;
			default: state_nxt = NVW_IDLE;
		endcase
	end

	assign busy_nxt = (state_nxt != NVW_IDLE);

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			state_r <= NVW_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign tif.start = store_wr_ok;
	assign tif.clk_sel = ctrl_r[`NVW_CS_MSB:`NVW_CS_LSB];
	assign tif.timer_src = timer_out_i;

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			wr_addr_r <= '0;
			wr_data_r <= 8'h00;
		end else if (store_wr_ok) begin
			wr_addr_r <= store_idx;
			wr_data_r <= mem_wdata_i;
		end
	end

	// Cells are only committed at the end of the write; no reset
	always_ff @(posedge sys_clk_i) begin
		if (state_r == NVW_BUSY && tif.done) begin
			store_mem[wr_addr_r] <= wr_data_r; // [RULE_01] [RULE_02]
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= (state_r == NVW_BUSY) && tif.done; // [RULE_03]
		end
	end

	// ==========================================
	// Control register
	// Write enable only sticks when read enable was already set
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			ctrl_r <= `NVW_CTRL_RST; // [RULE_04]
		end else if (mem_wr_i && ctrl_hit) begin
			ctrl_r[`NVW_FIX0_BIT] <= 1'b0; // [RULE_15] [RULE_06]
			ctrl_r[`NVW_CS_MSB:`NVW_CS_LSB] <= ctrl_wval[`NVW_CS_MSB:`NVW_CS_LSB];
			ctrl_r[`NVW_FIX1_BIT] <= 1'b1; // [RULE_15]
			ctrl_r[`NVW_RE_BIT] <= ctrl_wval[`NVW_RE_BIT];
			ctrl_r[`NVW_WST_BIT] <= busy_nxt; // [RULE_11]
			ctrl_r[`NVW_WE_BIT] <= ctrl_wval[`NVW_WE_BIT] & ctrl_wval[`NVW_RE_BIT] &
				ctrl_r[`NVW_RE_BIT]; // [RULE_09] [RULE_14]
		end else begin
			ctrl_r[`NVW_WST_BIT] <= busy_nxt; // [RULE_10] [RULE_11]
		end
	end

	// ==========================================
	// Read path
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= 1'b0;
			if (mem_rd_i && ctrl_hit) begin
				rdata_r <= ctrl_r;
				rvalid_r <= 1'b1;
			end else if (mem_rd_i && store_hit && !busy && ctrl_r[`NVW_RE_BIT]) begin
				rdata_r <= store_mem[store_idx]; // [RULE_09] [RULE_11]
				rvalid_r <= 1'b1;
			end
		end
	end

	assign mem_rdata_o = rdata_r;
	assign mem_rvalid_o = rvalid_r;
	assign nv_write_done_irq_o = irq_r;

	// ==========================================
	// Checks
	sequence seq_write_start;
		store_wr_ok ##1 busy;
	endsequence

	sequence seq_write_end;
		(state_r == NVW_BUSY) && tif.done ##1 irq_r ##1 !irq_r;
	endsequence

	reset_value_a: assert property (@(posedge sys_clk_i) // [RULE_04]
		$past(srst_i) && !srst_i |-> ctrl_r == 8'h08)
		else $error("control register not 08H after reset");

	fixed_bits_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE_15]
		!ctrl_r[7] && ctrl_r[3])
		else $error("fixed control bits changed");

	enable_pair_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE_14]
		ctrl_r[0] |-> ctrl_r[2])
		else $error("write enable set without read enable");

	status_mirror_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE_11]
		ctrl_r[1] == busy)
		else $error("status bit does not follow write progress");

	timer_busy_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE_11]
		(state_r == NVW_BUSY) && !tif.done |-> tif.busy)
		else $error("write timer idle while write in progress");

	write_start_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE_10]
		store_wr_ok |-> seq_write_start)
		else $error("enabled store write did not start");

	busy_ignore_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE_12]
		busy && mem_wr_i && store_hit |=> $stable(wr_addr_r) && $stable(wr_data_r))
		else $error("store write during busy was taken");

	done_irq_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE_03]
		(state_r == NVW_BUSY) && tif.done |-> seq_write_end)
		else $error("write end did not pulse interrupt");

	read_block_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE_11]
		mem_rd_i && store_hit && busy |=> !rvalid_r)
		else $error("store read answered during write");

	byte_write_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE_05]
		mem_wr_i && ctrl_hit && !mem_bit_i |=> ctrl_r[6:4] == $past(mem_wdata_i[6:4]))
		else $error("byte write to clock select lost");
endmodule

//--- bench/nvw_cpu_model.sv
`timescale 1ns/100ps
module nvw_cpu_model (
	input wire logic sys_clk_i,
	output logic [15:0] mem_addr_o,
	output logic mem_rd_o,
	output logic mem_wr_o,
	output logic mem_bit_o,
	output logic [2:0] mem_bit_sel_o,
	output nvw_pkg::nvw_byte_type mem_wdata_o,
	input wire nvw_pkg::nvw_byte_type mem_rdata_i,
	input wire logic mem_rvalid_i
);
	import nvw_pkg::*;
	initial begin
		mem_addr_o = 16'h0000;
		mem_rd_o = 1'b0;
		mem_wr_o = 1'b0;
		mem_bit_o = 1'b0;
		mem_bit_sel_o = 3'h0;
		mem_wdata_o = 8'h00;
	end
	// Byte read; the answer may land one or two cycles on
	task automatic rd(input logic [15:0] a, output logic ok, output nvw_byte_type d);
		@(negedge sys_clk_i);
		mem_addr_o = a;
		mem_rd_o = 1'b1;
		@(negedge sys_clk_i);
		mem_rd_o = 1'b0;
		ok = (mem_rvalid_i === 1'b1);
		d = mem_rdata_i;
		@(negedge sys_clk_i);
		if (!ok) begin
			ok = (mem_rvalid_i === 1'b1);
			d = mem_rdata_i;
		end
	endtask
	task automatic wr(input logic [15:0] a, input nvw_byte_type d, input logic b,
		input logic [2:0] s);
		@(negedge sys_clk_i);
		mem_addr_o = a;
		mem_wdata_o = d;
		mem_bit_o = b;
		mem_bit_sel_o = s;
		mem_wr_o = 1'b1;
		@(negedge sys_clk_i);
		mem_wr_o = 1'b0;
		mem_bit_o = 1'b0;
	endtask
endmodule

//--- bench/nvw_write_control_test.sv
`timescale 1ns/100ps
module nvw_write_control_test;
	import nvw_pkg::*;
	logic sys_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic timer_out = 1'b0;
	logic [15:0] addr;
	logic rd, wr, bitw;
	logic [2:0] bsel;
	nvw_byte_type wdata, rdata;
	logic rvalid, irq;
	int err_count = 0;
	int n_compared = 0;
	int cyc = 0;
	localparam logic [15:0] CTRL = 16'hFFD8;
	// ==========
	// Clock, timeout, instances
	always #20 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 30000) begin
			err_count++;
			conclude();
		end
	end
	nvw_write_control nvw_write_control_inst (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
		.mem_addr_i(addr), .mem_rd_i(rd), .mem_wr_i(wr), .mem_bit_i(bitw),
		.mem_bit_sel_i(bsel), .mem_wdata_i(wdata), .timer_out_i(timer_out),
		.mem_rdata_o(rdata), .mem_rvalid_o(rvalid), .nv_write_done_irq_o(irq));
	nvw_cpu_model nvw_cpu_model_inst (.sys_clk_i(sys_clk_i), .mem_addr_o(addr),
		.mem_rd_o(rd), .mem_wr_o(wr), .mem_bit_o(bitw), .mem_bit_sel_o(bsel),
		.mem_wdata_o(wdata), .mem_rdata_i(rdata), .mem_rvalid_i(rvalid));
	// ==========
	// Helpers
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic rdc(input string nm, input logic [15:0] a, input logic eok,
		input nvw_byte_type ed);
		logic ok;
		nvw_byte_type d;
		nvw_cpu_model_inst.rd(a, ok, d);
		chk({nm, " answered"}, {15'h0, ok}, {15'h0, eok});
		if (eok) chk(nm, {8'h00, d}, {8'h00, ed});
	endtask
	// Counts cycles to the done pulse, toggling the timer output if asked
	task automatic wait_irq(input logic tmr, output int n, output int rises);
		n = 0;
		rises = 0;
		while (irq !== 1'b1 && n < 20000) begin
			@(negedge sys_clk_i);
			n++;
			if (tmr && irq !== 1'b1 && n % 2 == 0) begin
				timer_out = ~timer_out;
				if (timer_out) rises++;
			end
		end
	endtask
	// ==========
	// Scenarios
	task automatic t_reset();
		rdc("ctrl reset", CTRL, 1'b1, 8'h08);
		rdc("unmapped", 16'hFFD9, 1'b0, 8'h00);
		rdc("standby read", 16'hFD00, 1'b0, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_fields();
		nvw_cpu_model_inst.wr(CTRL, 8'hFF, 1'b0, 3'h0);
		rdc("fixed bits", CTRL, 1'b1, 8'h7C);
		nvw_cpu_model_inst.wr(CTRL, 8'h0D, 1'b0, 3'h0);
		rdc("read write", CTRL, 1'b1, 8'h0D);
		nvw_cpu_model_inst.wr(CTRL, 8'h00, 1'b1, 3'h2);
		rdc("re clear", CTRL, 1'b1, 8'h08);
		nvw_cpu_model_inst.wr(CTRL, 8'h09, 1'b0, 3'h0);
		rdc("we only", CTRL, 1'b1, 8'h08);
		nvw_cpu_model_inst.wr(CTRL, 8'h01, 1'b1, 3'h2);
		nvw_cpu_model_inst.wr(CTRL, 8'h0E, 1'b0, 3'h0);
		rdc("status ro", CTRL, 1'b1, 8'h0C);
		$display("test fields done");
	endtask
	task automatic t_write();
		int n, r;
		nvw_cpu_model_inst.wr(CTRL, 8'h0D, 1'b0, 3'h0);
		nvw_cpu_model_inst.wr(16'hFD05, 8'hA5, 1'b0, 3'h0);
		rdc("busy status", CTRL, 1'b1, 8'h0F);
		rdc("busy read", 16'hFD05, 1'b0, 8'h00);
		nvw_cpu_model_inst.wr(16'hFD05, 8'h5A, 1'b0, 3'h0);
		wait_irq(1'b0, n, r);
		chk("irq seen", {15'h0, irq}, 16'h0001);
		chk("write len", {15'h0, n >= 1150 && n <= 1166}, 16'h0001);
		@(negedge sys_clk_i);
		rdc("idle status", CTRL, 1'b1, 8'h0D);
		rdc("stored", 16'hFD05, 1'b1, 8'hA5);
		$display("test write done");
	endtask
	task automatic t_timer();
		int n, r;
		nvw_cpu_model_inst.wr(CTRL, 8'h6D, 1'b0, 3'h0);
		nvw_cpu_model_inst.wr(16'hFD1F, 8'h3C, 1'b0, 3'h0);
		wait_irq(1'b1, n, r);
		chk("timer edges", r[15:0], 16'd145);
		@(negedge sys_clk_i);
		rdc("timer stored", 16'hFD1F, 1'b1, 8'h3C);
		$display("test timer done");
	endtask
	task automatic t_divider();
		int n, r;
		nvw_cpu_model_inst.wr(CTRL, 8'h1D, 1'b0, 3'h0);
		nvw_cpu_model_inst.wr(16'hFD10, 8'hC3, 1'b0, 3'h0);
		wait_irq(1'b0, n, r);
		chk("irq div16", {15'h0, irq}, 16'h0001);
		chk("div16 len", {15'h0, n >= 2305 && n <= 2326}, 16'h0001);
		@(negedge sys_clk_i);
		rdc("div16 stored", 16'hFD10, 1'b1, 8'hC3);
		$display("test divider done");
	endtask
	// Prohibited select never finishes; a reset in mid-run abandons the write
	task automatic t_prohibited();
		int i;
		logic seen;
		seen = 1'b0;
		nvw_cpu_model_inst.wr(CTRL, 8'h7D, 1'b0, 3'h0);
		nvw_cpu_model_inst.wr(16'hFD02, 8'h99, 1'b0, 3'h0);
		for (i = 0; i < 400; i++) begin
			@(negedge sys_clk_i);
			if (irq !== 1'b0) seen = 1'b1;
		end
		chk("prohib irq", {15'h0, seen}, 16'h0000);
		rdc("prohib busy", CTRL, 1'b1, 8'h7F);
		srst_i = 1'b1;
		repeat (2) @(negedge sys_clk_i);
		srst_i = 1'b0;
		chk("reset irq", {15'h0, irq}, 16'h0000);
		rdc("mid reset", CTRL, 1'b1, 8'h08);
		rdc("reset standby", 16'hFD02, 1'b0, 8'h00);
		$display("test prohibited done");
	endtask
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge sys_clk_i);
		srst_i = 1'b0;
		t_reset();
		t_fields();
		t_write();
		t_timer();
		t_divider();
		t_prohibited();
		conclude();
	end
endmodule
